// [hw/gwfr_receiver.sv]
// Gap write frame receiver: decodes field gaps into a block write
`timescale 1ns/1ps
`default_nettype none
module gwfr_receiver (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Field clock from the antenna front end, stops during a gap
  input  wire logic        field_clk,
  // Block write request
  output logic             prog_valid,
  output logic [2:0]       prog_addr,
  output logic [31:0]      prog_data,
  output logic             prog_lock,
  // Status
  output logic             write_mode,
  output logic             frame_error
);
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  // Shift register holds opcode, lock bit, data word and address
  localparam int unsigned SHIFT_W = gwfr_pkg::FRAME_BITS;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 s1;
    logic                 s2;
    logic                 s3;
    gwfr_pkg::gwfr_mode_t mode;
    logic [7:0]           idle;
    logic [7:0]           cnt;
    logic [5:0]           nbits;
    logic [SHIFT_W-1:0]   shift;
    logic                 pvalid;
    logic [2:0]           paddr;
    logic [31:0]          pdata;
    logic                 plock;
    logic                 err;
  } gwfr_state_t;

  gwfr_state_t st;
  gwfr_state_t next_st;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Decode a counted interval: {valid, value}
  function automatic logic [1:0] gwfr_decode(input logic [7:0] n);
    logic [1:0] res;
    res = 2'h0;
    if (n >= gwfr_pkg::ZERO_MIN && n <= gwfr_pkg::ZERO_MAX) begin
      res = 2'h2;
    end else if (n == gwfr_pkg::ONE_A || n == gwfr_pkg::ONE_B) begin
      res = 2'h3;
    end
    return res;
  endfunction

  // Count up by one, holding at the top value
  function automatic logic [7:0] gwfr_step(input logic [7:0] n);
    logic [7:0] res;
    res = n;
    if (n != gwfr_pkg::CNT_MAX) begin
      res = n + 8'h01;
    end
    return res;
  endfunction

  // Complete write frame: exact bit count and write opcode
  function automatic logic gwfr_frame_ok(
    input logic [5:0]         nb,
    input logic [SHIFT_W-1:0] fr
  );
    logic ok;
    ok = 1'b0;
    if (nb == gwfr_pkg::FRAME_BITS_W) begin
      if (fr[gwfr_pkg::OPCODE_POS +: 2] == gwfr_pkg::WRITE_OPCODE) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // Field edges, gaps and frame end
  // ---------------------------------------------------------------
  logic        rise;
  logic        gap_seen;
  logic        run_over;
  logic        in_frame;
  logic [1:0]  dec;
  logic        frame_ok;
  logic        frame_lock;
  logic [31:0] frame_data;
  logic [2:0]  frame_addr;

  // Only the later stages are read: the first may be metastable
  assign rise     = st.s2 & ~st.s3;
  // A gap ends at the first field edge after a long quiet time
  assign gap_seen = rise && st.idle >= gwfr_pkg::GAP_MIN_W;
  // Field ran past the longest valid interval without a gap
  assign run_over = rise && !gap_seen && st.cnt >= gwfr_pkg::ONE_B;
  // Write mode covers the start gap and every bit after it
  assign in_frame = st.mode != gwfr_pkg::GWFR_READ;
  // Interval value, and whether the whole frame is good
  assign dec      = gwfr_decode(st.cnt);
  assign frame_ok = gwfr_frame_ok(st.nbits, st.shift);

  // Received fields, first bit on top
  assign frame_lock = st.shift[gwfr_pkg::LOCK_POS];
  assign frame_data = st.shift[gwfr_pkg::ADDR_BITS +: 32];
  assign frame_addr = st.shift[2:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Synchroniser and edge history
    next_st.s1 = field_clk;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.pvalid = 1'b0;

    // Quiet time since the last field edge
    if (rise) begin
      next_st.idle = 8'h00;
    end else begin
      next_st.idle = gwfr_step(st.idle);
    end

    // Field clocks since the last gap; the edge ending a gap is the first
    if (gap_seen) begin
      next_st.cnt = 8'h01;
    end else if (rise && in_frame) begin
      next_st.cnt = gwfr_step(st.cnt);
    end

    // Each gap opens a frame or closes one bit interval
    if (gap_seen) begin
      unique case (st.mode)
        gwfr_pkg::GWFR_READ: begin
          next_st.mode = gwfr_pkg::GWFR_START;
          next_st.nbits = 6'h00;
          next_st.shift = '0;
          next_st.err = 1'b0;
        end
        gwfr_pkg::GWFR_START, gwfr_pkg::GWFR_BITS: begin
          if (!dec[1]) begin
            // Invalid interval: leave write mode
            next_st.mode = gwfr_pkg::GWFR_READ;
            next_st.err = 1'b1;
          end else if (st.nbits == gwfr_pkg::FRAME_BITS_W) begin
            // Extra bit: frame too long, discard
            next_st.mode = gwfr_pkg::GWFR_READ;
            next_st.err = 1'b1;
          end else begin
            next_st.mode = gwfr_pkg::GWFR_BITS;
            next_st.shift = {st.shift[SHIFT_W-2:0], dec[0]};
            next_st.nbits = st.nbits + 6'h01;
          end
        end
        default: begin
          next_st.mode = gwfr_pkg::GWFR_READ;
        end
      endcase
    end

    // Unbroken field after the bits: the frame is over
    if (run_over && st.mode == gwfr_pkg::GWFR_BITS) begin
      next_st.mode = gwfr_pkg::GWFR_READ;
      if (frame_ok) begin
        // Exact count and write opcode: program the block
        next_st.pvalid = 1'b1;
        next_st.plock = frame_lock;
        next_st.pdata = frame_data;
        next_st.paddr = frame_addr;
      end else begin
        // Short or wrong frame: keep the old block contents
        next_st.err = 1'b1;
      end
    end else if (run_over && st.mode == gwfr_pkg::GWFR_START) begin
      // A start gap with no bits behind it programs nothing
      next_st.mode = gwfr_pkg::GWFR_READ;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prog_valid  = st.pvalid;
  assign prog_addr   = st.paddr;
  assign prog_data   = st.pdata;
  assign prog_lock   = st.plock;
  assign write_mode  = st.mode != gwfr_pkg::GWFR_READ;
  assign frame_error = st.err;
endmodule
`default_nettype wire

// [hw/gwfr_pkg.sv]
// Constants and types for the gap write frame receiver
`default_nettype none
package gwfr_pkg;
  // Frame layout: opcode, lock bit, 32 data bits, 3 address bits
  localparam int unsigned OPCODE_BITS = 2;
  localparam logic [1:0]  WRITE_OPCODE = 2'h2;
  localparam int unsigned DATA_BITS = 32;
  localparam int unsigned ADDR_BITS = 3;
  localparam int unsigned FRAME_BITS = OPCODE_BITS + 1 + DATA_BITS + ADDR_BITS;
  localparam logic [5:0]  FRAME_BITS_W = 6'(FRAME_BITS);
  localparam int unsigned LOCK_POS = DATA_BITS + ADDR_BITS;
  localparam int unsigned OPCODE_POS = LOCK_POS + 1;

  // Interval decode windows, in field clocks between gaps
  localparam logic [7:0] ZERO_MIN = 8'h10;
  localparam logic [7:0] ZERO_MAX = 8'h20;
  localparam logic [7:0] ONE_A    = 8'h30;
  localparam logic [7:0] ONE_B    = 8'h40;
  localparam logic [7:0] CNT_MAX  = 8'hff;

  // Gap is field absent this long, given in ns and converted to clocks
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned GAP_MIN_NS = 2_000;
  localparam int unsigned GAP_MIN_CYC =
    (GAP_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] GAP_MIN_W = 8'(GAP_MIN_CYC);

  typedef enum logic [1:0] {
    GWFR_READ  = 2'h0,
    GWFR_START = 2'h1,
    GWFR_BITS  = 2'h2
  } gwfr_mode_t;
endpackage
`default_nettype wire

// [tb/gwfr_checker.sv]
// Port assertions for the gap write frame receiver
`timescale 1ns/1ps
`default_nettype none
module gwfr_checker (
  // Watched ports
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        prog_valid,
  input wire logic [2:0]  prog_addr,
  input wire logic [31:0] prog_data,
  input wire logic        prog_lock,
  input wire logic        write_mode,
  input wire logic        frame_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  pulse_once_a: assert property (prog_valid |=> !prog_valid)
    else $error("long prog pulse");
  prog_clean_a: assert property (prog_valid |-> !frame_error
      && !write_mode)
    else $error("prog with error");
  data_hold_a: assert property ($changed(prog_data) |-> prog_valid)
    else $error("data moved");
  addr_hold_a: assert property ($changed(prog_addr) |-> prog_valid)
    else $error("addr moved");
  lock_hold_a: assert property ($changed(prog_lock) |-> prog_valid)
    else $error("lock moved");
  err_exit_a: assert property ($rose(frame_error) |-> !write_mode)
    else $error("error in write");
  err_clear_a: assert property ($fell(frame_error) |-> write_mode)
    else $error("error cleared");
  start_hold_a: assert property ($rose(write_mode) |=> write_mode[*8])
    else $error("early exit");
endmodule
`default_nettype wire

// [tb/gwfr_station.sv]
// Base station model: sends write frames as field gaps
`timescale 1ns/1ps
`default_nettype none
module gwfr_station (
  // Field clock to the transponder
  output logic field_clk
);
  initial field_clk = 1'b0;
  task automatic burst(input int n);
    repeat (n) begin
      #80 field_clk = 1'b1;
      #80 field_clk = 1'b0;
    end
  endtask
  // Bits sent msb first, each closed by a still field
  task automatic frame(input logic [38:0] b, input int nb, n0, n1);
    #3000;
    for (int i = nb - 1; i >= 0; i--) begin
      burst(b[i] ? n1 : n0);
      #3000;
    end
    burst(70);
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the gap write frame receiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [38:0] b; int nb, n0, n1; logic ok;} gwfr_row_t;
  logic        clk, reset_n, field_clk, prog_valid, prog_lock;
  logic        write_mode, frame_error;
  logic [2:0]  prog_addr;
  logic [31:0] prog_data;
  logic [35:0] last = '0;
  int          n_mismatch = 0, tests_run = 0, n_prog = 0, k;
  gwfr_row_t   rows [6] = '{
    '{{3'h2, 1'b1, 32'h8000_0001, 3'h5}, 38, 16, 48, 1'b1},
    '{{3'h2, 1'b0, 32'h0000_0300, 3'h2}, 38, 32, 64, 1'b1},
    '{{3'h1, 1'b0, 32'h0, 3'h7}, 38, 16, 48, 1'b0},
    '{{3'h2, 1'b0, 32'h0, 3'h3}, 37, 16, 48, 1'b0},
    '{{3'h2, 1'b0, 32'h0, 3'h3}, 39, 16, 48, 1'b0},
    '{39'h0, 3, 40, 40, 1'b0}};
  gwfr_station i_st (.field_clk(field_clk));
  gwfr_receiver i_dut (.clk(clk), .reset_n(reset_n), .field_clk(field_clk),
    .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data),
    .prog_lock(prog_lock), .write_mode(write_mode),
    .frame_error(frame_error));
  task automatic check(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (prog_valid === 1'b1) n_prog++;
  initial begin
    #1900000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      k = n_prog;
      i_st.frame(rows[i].b, rows[i].nb, rows[i].n0, rows[i].n1);
      repeat (10) @(negedge clk);
      if (rows[i].ok) last = rows[i].b[35:0];
      check(n_prog === k + int'(rows[i].ok), "prog count");
      check({prog_lock, prog_data, prog_addr} === last, "fields");
      check(frame_error === !rows[i].ok, "error flag");
      check(write_mode === 1'b0, "write mode");
      $display("row %0d done", i);
    end
    k = n_prog;
    fork
      i_st.frame(rows[0].b, 38, 16, 48);
      begin
        #20000;
        @(negedge clk);
        check(write_mode === 1'b1, "in frame");
        reset_n = 1'b0;
        @(negedge clk);
        check({prog_valid, write_mode, frame_error} === 3'h0, "rst");
        check({prog_lock, prog_data, prog_addr} === 36'h0, "rst fields");
        reset_n = 1'b1;
      end
    join
    repeat (10) @(negedge clk);
    check(n_prog === k && prog_data === '0, "cut frame");
    check(frame_error === 1'b1, "cut frame error");
    $display("reset test done");
    tally_and_finish;
  end
endmodule
bind gwfr_receiver gwfr_checker i_chk (.clk(clk), .reset_n(reset_n),
  .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data),
  .prog_lock(prog_lock), .write_mode(write_mode), .frame_error(frame_error));
`default_nettype wire
